// ==== design/asbwp_pkg.sv ====
// Package: pin widths, state codes and timing counts for the SRAM host port
package asbwp_pkg;

    localparam int ADDR_W = 21;
    localparam int DATA_W = 8;

    // Clock period in picoseconds (40 MHz)
    localparam int CLK_PS = 25000;

    // Device timing in picoseconds, slower grade so both grades are met
    localparam int T_RC_PS  = 12000;
    localparam int T_AA_PS  = 12000;
    localparam int T_WC_PS  = 12000;
    localparam int T_WP_PS  = 10000;
    localparam int T_DW_PS  = 7000;
    localparam int T_OHZ_PS = 5000;
    localparam int T_OW_PS  = 2000;

    function automatic int cyc_up(input int ps);
        int n;
        n = (ps + CLK_PS - 1) / CLK_PS;
        return (n < 1) ? 1 : n;
    endfunction

    // Read: address and selects stand this many cycles before sampling
    localparam int RD_CYC = cyc_up(T_AA_PS + T_RC_PS - T_RC_PS);
    // Write: strobe low for covering pulse width and output turn-off time
    localparam int WP_CYC = cyc_up(T_WP_PS + T_OHZ_PS);
    // Idle after a write before the device may drive again
    localparam int REC_CYC = cyc_up(T_OW_PS);
    localparam int CNT_W = 4;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_RD    = 3'b001,
        ST_WSET  = 3'b010,
        ST_WPUL  = 3'b011,
        ST_WEND  = 3'b100,
        ST_REC   = 3'b101
    } asbwp_state_e;

endpackage

// ==== design/asbwp_pin_sync.sv ====
// Two-flop synchroniser for the data lanes read back from the memory
`timescale 1ns/1ps
`default_nettype none
module asbwp_pin_sync
(
    // Clock and control
    input  wire logic                     sys_clk,
    input  wire logic                     srst,
    input  wire logic                     clk_en,
    // Data
    input  wire logic [asbwp_pkg::DATA_W-1:0] pin_in,
    output logic      [asbwp_pkg::DATA_W-1:0] sync_out
);
    import asbwp_pkg::*;

    logic [DATA_W-1:0] meta_ff;
    logic [DATA_W-1:0] sync_ff;

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            meta_ff <= 8'h00;
            sync_ff <= 8'h00;
        end
        else if (clk_en)
        begin
            meta_ff <= pin_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;
endmodule
`default_nettype wire

// ==== design/asbwp_host.sv ====
// Host controller that sequences the byte-wide asynchronous SRAM pins
`timescale 1ns/1ps
`default_nettype none
module asbwp_host
(
    // Clock, reset, enable
    input  wire logic                         sys_clk,
    input  wire logic                         srst,
    input  wire logic                         clk_en,
    // User request
    input  wire logic                         req_valid,
    input  wire logic                         req_write,
    input  wire logic [asbwp_pkg::ADDR_W-1:0] req_addr,
    input  wire logic [asbwp_pkg::DATA_W-1:0] req_wdata,
    output logic                              req_ready,
    // User answer
    output logic                              rsp_valid,
    output logic      [asbwp_pkg::DATA_W-1:0] rsp_rdata,
    // Memory pins
    output logic      [asbwp_pkg::ADDR_W-1:0] word_index_lines,
    output logic                              chip_select_n,
    output logic                              chip_select_high_active,
    output logic                              write_strobe_n,
    output logic                              output_gate_n,
    input  wire logic [asbwp_pkg::DATA_W-1:0] byte_lane_in,
    output logic      [asbwp_pkg::DATA_W-1:0] byte_lane_out,
    output logic                              byte_lane_oe
);
    import asbwp_pkg::*;

    asbwp_state_e      state_ff;
    asbwp_state_e      nxt_state;
    logic [CNT_W-1:0]  cnt_ff;
    logic [CNT_W-1:0]  nxt_cnt;
    logic [ADDR_W-1:0] addr_ff;
    logic [DATA_W-1:0] wdata_ff;
    logic [DATA_W-1:0] rdata_ff;
    logic              rsp_ff;
    logic              sel_ff;
    logic              we_ff;
    logic              oe_ff;
    logic              drv_ff;
    logic [DATA_W-1:0] lane_sync;

    wire cnt_done = (cnt_ff == '0);
    wire take     = (state_ff == ST_IDLE) && req_valid;
    // Synchroniser adds two cycles, so read waits cover that latency too
    localparam logic [CNT_W-1:0] RD_LOAD  = CNT_W'(RD_CYC + 2);
    localparam logic [CNT_W-1:0] WP_LOAD  = CNT_W'(WP_CYC - 1);
    localparam logic [CNT_W-1:0] REC_LOAD = CNT_W'(REC_CYC - 1);

    asbwp_pin_sync u_sync
    (
        .sys_clk  (sys_clk),
        .srst     (srst),
        .clk_en   (clk_en),
        .pin_in   (byte_lane_in),
        .sync_out (lane_sync)
    );

    // Address is latched only in idle, when no overlap can be open
    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_done ? cnt_ff : cnt_ff - 1'b1;
        case (state_ff)
            ST_IDLE:
                if (req_valid)
                begin
                    nxt_state = req_write ? ST_WSET : ST_RD;
                    nxt_cnt   = RD_LOAD;
                end
            ST_RD:
                if (cnt_done)
                    nxt_state = ST_IDLE;
            ST_WSET:
            begin
                nxt_state = ST_WPUL;
                nxt_cnt   = WP_LOAD;
            end
            ST_WPUL:
                if (cnt_done)
                    nxt_state = ST_WEND;
            ST_WEND:
            begin
                nxt_state = ST_REC;
                nxt_cnt   = REC_LOAD;
            end
            ST_REC:
                if (cnt_done)
                    nxt_state = ST_IDLE;
            default:
                nxt_state = ST_IDLE;
        endcase
    end

    // Pin intent for the next cycle
    wire nxt_sel = (nxt_state != ST_IDLE) && (nxt_state != ST_REC);
    wire nxt_we  = (nxt_state == ST_WPUL);
    wire nxt_oe  = (nxt_state == ST_RD);
    // Data driven from set-up through strobe end and one hold cycle
    wire nxt_drv = (nxt_state == ST_WSET) || (nxt_state == ST_WPUL)
                   || (nxt_state == ST_WEND);
    wire rd_last = (state_ff == ST_RD) && cnt_done;

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            state_ff <= ST_IDLE;
            cnt_ff   <= '0;
            sel_ff   <= 1'b0;
            we_ff    <= 1'b0;
            oe_ff    <= 1'b0;
            drv_ff   <= 1'b0;
            rsp_ff   <= 1'b0;
        end
        else if (clk_en)
        begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
            sel_ff   <= nxt_sel;
            we_ff    <= nxt_we;
            oe_ff    <= nxt_oe;
            drv_ff   <= nxt_drv;
            rsp_ff   <= rd_last;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            addr_ff  <= '0;
            wdata_ff <= 8'h00;
            rdata_ff <= 8'h00;
        end
        else if (clk_en)
        begin
            if (take)
            begin
                addr_ff  <= req_addr;
                wdata_ff <= req_wdata;
            end
            if (rd_last)
                rdata_ff <= lane_sync;
        end
    end

    assign req_ready               = (state_ff == ST_IDLE);
    assign rsp_valid               = rsp_ff;
    assign rsp_rdata               = rdata_ff;
    assign word_index_lines        = addr_ff;
    assign chip_select_n           = ~sel_ff;
    assign chip_select_high_active = sel_ff;
    assign write_strobe_n          = ~we_ff;
    assign output_gate_n           = ~oe_ff;
    assign byte_lane_out           = wdata_ff;
    assign byte_lane_oe            = drv_ff;
endmodule
`default_nettype wire

// ==== tb/asbwp_host_monitor.sv ====
// Checker for the pin sequencing of the SRAM host port
`timescale 1ns/1ps
`default_nettype none
module asbwp_host_monitor
(
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        srst,
    input wire logic        clk_en,
    // Request side
    input wire logic        req_valid,
    input wire logic        req_write,
    input wire logic        req_ready,
    input wire logic        rsp_valid,
    // Memory pins
    input wire logic [20:0] word_index_lines,
    input wire logic        chip_select_n,
    input wire logic        write_strobe_n,
    input wire logic        output_gate_n,
    input wire logic [7:0]  byte_lane_out,
    input wire logic        byte_lane_oe
);
    default clocking @(posedge sys_clk); endclocking
    // A frozen enable stretches every sequence, so attempts then are dropped
    default disable iff (srst || !clk_en);
    wire rd_take = req_valid && req_ready && !req_write;
    wire wr_take = req_valid && req_ready && req_write;

    a_read_strobe_hi: assert property (
        !output_gate_n |-> write_strobe_n) else $error("strobe in read");
    a_read_length: assert property (
        $fell(output_gate_n) |-> !output_gate_n [*4] ##1 output_gate_n)
        else $error("read length off");
    a_read_answer: assert property (
        rd_take |-> ##5 rsp_valid) else $error("read answer late");
    a_write_pulse: assert property (
        wr_take |-> ##1 write_strobe_n ##1 !write_strobe_n ##1 write_strobe_n)
        else $error("write pulse off");
    a_addr_held: assert property (
        !chip_select_n && $past(!chip_select_n) |-> $stable(word_index_lines))
        else $error("address moved while selected");
    a_addr_moves: assert property (
        $changed(word_index_lines) |-> $past(chip_select_n) && write_strobe_n)
        else $error("address moved in write");
    a_wr_data_held: assert property (
        !write_strobe_n |-> byte_lane_oe && $stable(byte_lane_out)
        ##1 byte_lane_oe && $stable(byte_lane_out)) else $error("data moved");
    a_no_clash: assert property (
        byte_lane_oe |-> output_gate_n) else $error("lane contention");
endmodule
bind asbwp_host asbwp_host_monitor u_mon (.*);
`default_nettype wire

// ==== tb/asbwp_sram_model.sv ====
// Behavioural byte-wide static memory facing the host port
`timescale 1ns/1ps
`default_nettype none
module asbwp_sram_model
(
    // Pins from the host
    input  wire logic [20:0] word_index_lines,
    input  wire logic        chip_select_n,
    input  wire logic        chip_select_high_active,
    input  wire logic        write_strobe_n,
    input  wire logic        output_gate_n,
    input  wire logic [7:0]  byte_lane_out,
    input  wire logic        byte_lane_oe,
    // Resolved lane level
    output logic      [7:0]  byte_lane_in
);
    logic [7:0] mem [int];
    logic [7:0] last;
    wire sel = !chip_select_n && chip_select_high_active;
    wire drv = sel && !output_gate_n && write_strobe_n;
    // Strobe rise while selected closes the overlap
    always @(posedge write_strobe_n)
        if (sel)
            mem[word_index_lines] = byte_lane_out;
    // Released lanes show the inverse of the last level, not a held value
    always @*
    begin
        if (byte_lane_oe)
            byte_lane_in = byte_lane_out;
        else if (drv)
            byte_lane_in = mem[word_index_lines];
        else
            byte_lane_in = ~last;
        if (byte_lane_oe || drv)
            last = byte_lane_in;
    end
endmodule
`default_nettype wire

// ==== tb/asbwp_host_tb.sv ====
// Self-checking bench for the SRAM host port and its memory model
`timescale 1ns/1ps
`default_nettype none
module asbwp_host_tb;
    logic        sys_clk, srst, clk_en, req_valid, req_write, req_ready;
    logic        rsp_valid, chip_select_n, chip_select_high_active;
    logic        write_strobe_n, output_gate_n, byte_lane_oe;
    logic [20:0] req_addr, word_index_lines;
    logic [7:0]  req_wdata, rsp_rdata, byte_lane_in, byte_lane_out;
    int          n_fail = 0;
    int          n_tests = 0;

    asbwp_host       u_dut (.*);
    asbwp_sram_model u_mem (.*);

    initial
    begin
        sys_clk = 0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e)
        begin
            n_fail++;
            $display("wrong value at %0t: %h vs %h", $time, s, e);
        end
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic tick;
        @(posedge sys_clk);
        #1;
    endtask

    task automatic go(input logic w, input logic [20:0] a, input logic [7:0] d);
        int n;
        // One edge between requests so valid is never set twice in a step
        tick;
        {req_valid, req_write, req_addr, req_wdata} = {1'b1, w, a, d};
        for (n = 0; req_ready !== 1'b1 && n < 9; n++)
            tick;
        tick;
        req_valid = 0;
        if (n == 9)
        begin
            n_fail++;
            test_done;
        end
    endtask

    task automatic rd(input logic [20:0] a, input logic [7:0] e);
        int n;
        go(1'b0, a, 8'h00);
        for (n = 1; rsp_valid !== 1'b1 && n < 9; n++)
            tick;
        chk(n, 5);
        chk(rsp_rdata, e);
        if (n == 9)
            test_done;
    endtask

    // Enable held low mid-read: counters, pins and answer must wait it out
    task automatic t_freeze;
        int n;
        go(1'b0, 21'h000000, 8'h00);
        clk_en = 0;
        repeat (3) tick;
        chk({output_gate_n, chip_select_n, rsp_valid}, 3'h0);
        clk_en = 1;
        for (n = 0; rsp_valid !== 1'b1 && n < 9; n++)
            tick;
        chk(n, 4);
        chk(rsp_rdata, 8'hA5);
        if (n == 9)
            test_done;
    endtask

    task automatic t_idle;
        chk({chip_select_n, chip_select_high_active, write_strobe_n,
             output_gate_n, byte_lane_oe, req_ready}, 6'h2D);
        chk(word_index_lines, 0);
    endtask

    task automatic t_edges;
        go(1'b1, 21'h000000, 8'hA5);
        go(1'b1, 21'h1FFFFF, 8'h5A);
        rd(21'h000000, 8'hA5);
        rd(21'h1FFFFF, 8'h5A);
    endtask

    // Walking address bit, writes then reads issued back to back
    task automatic t_b2b;
        for (int i = 0; i < 5; i++)
            go(1'b1, 21'h000001 << (i * 5), 8'h33 * 8'(i + 1));
        for (int i = 0; i < 5; i++)
            rd(21'h000001 << (i * 5), 8'h33 * 8'(i + 1));
    endtask

    task automatic t_over;
        go(1'b1, 21'h0ABCDE, 8'h01);
        go(1'b1, 21'h0ABCDE, 8'hFE);
        rd(21'h0ABCDE, 8'hFE);
        rd(21'h000000, 8'hA5);
    endtask

    initial
    begin
        {srst, clk_en} = 2'b11;
        {req_valid, req_write, req_addr, req_wdata} = '0;
        repeat (10) tick;
        srst = 0;
        t_idle;
        t_edges;
        t_b2b;
        t_over;
        t_freeze;
        test_done;
    end
endmodule
`default_nettype wire
